// ---- ext_irq_regs.svh ----
`ifndef EXT_IRQ_REGS_SVH
`define EXT_IRQ_REGS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define OFS_CONFIG 8'h24
`define OFS_CLEAR 8'h30
`define OFS_STATUS 8'h34
`define OFS_MASK 8'h38
`define OFS_PINS 8'h3c

// ---------------------------------------------------------------
// Field positions in the configuration and clear registers
// ---------------------------------------------------------------
`define P4_MODE_LSB 0
`define P4_EN_BIT 3
`define P5_MODE_LSB 4
`define P5_EN_BIT 7
`define P6_MODE_LSB 8
`define P6_EN_BIT 11
`define CLR_P4_BIT 4
`define CLR_P5_BIT 5
`define CLR_P6_BIT 6

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define CONFIG_RESET 16'h0000
`define MASK_RESET 3'h0

`endif

// ---- ext_irq_pkg.sv ----
`default_nettype none
package ext_irq_pkg;
	// Detection modes as stored in a three-bit field
	typedef enum logic [2:0] {
		MODE_RISE = 3'h0,
		MODE_FALL = 3'h1,
		MODE_BOTH = 3'h2,
		MODE_HIGH = 3'h3,
		MODE_LOW = 3'h4,
		MODE_FALL_ALT = 3'h5,
		MODE_BOTH_ALT = 3'h6,
		MODE_HIGH_ALT = 3'h7
	} detect_mode_t;

	// Per-pin configuration
	typedef struct packed {
		logic enable;
		detect_mode_t mode;
	} pin_cfg_t;

	// AXI4-Lite request side
	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} axil_req_t;

	// AXI4-Lite answer side
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axil_rsp_t;

	// Slave-side write states, one-hot
	typedef enum logic [2:0] {
		WR_IDLE = 3'b001,
		WR_COLLECT = 3'b010,
		WR_RESP = 3'b100
	} wr_state_t;
endpackage
`default_nettype wire

// ---- pin_detect.sv ----
`default_nettype none
module pin_detect (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic pin,
	input wire ext_irq_pkg::pin_cfg_t cfg,
	output logic hit
);
	import ext_irq_pkg::*;

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic last;
	} det_state_t;

	det_state_t s_q;
	det_state_t s_d;
	logic rise;
	logic fall;

	// ---------------------------------------------------------------
	// Synchroniser and edge history
	// ---------------------------------------------------------------
	// Only sync2 reads sync1; edges are taken from sync2 and last
	always_comb begin
		s_d = s_q;
		s_d.sync1 = pin;
		s_d.sync2 = s_q.sync1;
		s_d.last = s_q.sync2;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ---------------------------------------------------------------
	// Mode decode; codes 5 to 7 alias lower ones
	// ---------------------------------------------------------------
	assign rise = s_q.sync2 & ~s_q.last;
	assign fall = ~s_q.sync2 & s_q.last;

	always_comb begin
		case (cfg.mode)
			MODE_RISE: hit = rise;
			MODE_FALL, MODE_FALL_ALT: hit = fall;
			MODE_BOTH, MODE_BOTH_ALT: hit = rise | fall;
			MODE_HIGH, MODE_HIGH_ALT: hit = s_q.sync2;
			MODE_LOW: hit = ~s_q.sync2;
			default: hit = 1'b0;
		endcase
		hit = hit & cfg.enable;
	end
endmodule // pin_detect
`default_nettype wire

// ---- ext_irq_pin4_to_6_config.sv ----
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`include "ext_irq_regs.svh"
`default_nettype none
module ext_irq_pin4_to_6_config #(
	parameter int NUM_PINS = 3
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	input wire logic [NUM_PINS-1:0] gpio_in,
	output logic wake,
	output logic irq
);
	import ext_irq_pkg::*;

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [15:0] config_reg;
		logic [NUM_PINS-1:0] pending;
		logic [NUM_PINS-1:0] mask;
		wr_state_t wr_state;
		logic have_aw;
		logic have_w;
		logic [7:0] waddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} top_state_t;

	top_state_t s_q;
	top_state_t s_d;
	pin_cfg_t cfg [NUM_PINS];
	logic [NUM_PINS-1:0] hit;
	logic [NUM_PINS-1:0] clr;
	logic [NUM_PINS-1:0] pin_level;
	logic [31:0] wmask;
	logic do_write;

	// ---------------------------------------------------------------
	// Field extraction
	// ---------------------------------------------------------------
	assign cfg[0] = pin_cfg_t'(s_q.config_reg[`P4_EN_BIT:`P4_MODE_LSB]);
	assign cfg[1] = pin_cfg_t'(s_q.config_reg[`P5_EN_BIT:`P5_MODE_LSB]);
	assign cfg[2] = pin_cfg_t'(s_q.config_reg[`P6_EN_BIT:`P6_MODE_LSB]);

	// ---------------------------------------------------------------
	// Detectors, one per pin
	// ---------------------------------------------------------------
	for (genvar i = 0; i < NUM_PINS; i++) begin : g_det
		pin_detect u_det (
			.aclk(aclk),
			.aresetn(aresetn),
			.pin(gpio_in[i]),
			.cfg(cfg[i]),
			.hit(hit[i])
		);
	end

	// Raw pin level read back for debug, straight from the port
	assign pin_level = gpio_in;

	// Byte-lane mask from write strobes
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			wmask[b*8 +: 8] = {8{s_q.wstrb[b]}};
		end
	end

	assign do_write = s_q.wr_state == WR_COLLECT && s_q.have_aw && s_q.have_w;

	// Clear pulse only; nothing is stored, so the bit reads back zero
	assign clr = (do_write && s_q.waddr == `OFS_CLEAR && s_q.wstrb[0]) ?
		s_q.wdata[`CLR_P6_BIT:`CLR_P4_BIT] : '0;

	// ---------------------------------------------------------------
	// Next-state logic
	// ---------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		// Write channel: gather address and data in either order
		case (s_q.wr_state)
			WR_IDLE: begin
				s_d.have_aw = 1'b0;
				s_d.have_w = 1'b0;
				s_d.wr_state = WR_COLLECT;
			end
			WR_COLLECT: begin
				if (s_axi_awvalid && !s_q.have_aw) begin
					s_d.have_aw = 1'b1;
					s_d.waddr = s_axi_awaddr;
				end
				if (s_axi_wvalid && !s_q.have_w) begin
					s_d.have_w = 1'b1;
					s_d.wdata = s_axi_wdata;
					s_d.wstrb = s_axi_wstrb;
				end
				if (do_write) begin
					s_d.bresp = 2'b00;
					case (s_q.waddr)
						`OFS_CONFIG: begin
							s_d.config_reg = (s_q.config_reg & ~wmask[15:0]) |
								(s_q.wdata[15:0] & wmask[15:0]);
						end
						`OFS_MASK: begin
							if (s_q.wstrb[0]) begin
								s_d.mask = s_q.wdata[NUM_PINS-1:0];
							end
						end
						`OFS_STATUS, `OFS_CLEAR, `OFS_PINS: begin
						end
						default: s_d.bresp = 2'b10;
					endcase
					s_d.have_aw = 1'b0;
					s_d.have_w = 1'b0;
					s_d.wr_state = WR_RESP;
				end
			end
			WR_RESP: begin
				if (s_axi_bready) begin
					s_d.wr_state = WR_COLLECT;
				end
			end
			default: s_d.wr_state = WR_IDLE;
		endcase

		// Write-one-to-clear on status, or on the clear register;
		// a detection in the same cycle wins so no event is lost
		if (do_write && s_q.waddr == `OFS_STATUS && s_q.wstrb[0]) begin
			s_d.pending = s_q.pending & ~s_q.wdata[NUM_PINS-1:0];
		end else begin
			s_d.pending = s_q.pending & ~clr;
		end
		s_d.pending = s_d.pending | hit;

		// Read channel: one read in flight
		if (s_q.rvalid) begin
			if (s_axi_rready) begin
				s_d.rvalid = 1'b0;
			end
		end else if (s_axi_arvalid) begin
			s_d.rvalid = 1'b1;
			s_d.rresp = 2'b00;
			s_d.rdata = '0;
			case (s_axi_araddr)
				`OFS_CONFIG: s_d.rdata[15:0] = s_q.config_reg;
				`OFS_CLEAR: s_d.rdata = '0;
				`OFS_STATUS: s_d.rdata[NUM_PINS-1:0] = s_q.pending;
				`OFS_MASK: s_d.rdata[NUM_PINS-1:0] = s_q.mask;
				`OFS_PINS: s_d.rdata[NUM_PINS-1:0] = pin_level;
				default: s_d.rresp = 2'b10;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
			s_q.config_reg <= `CONFIG_RESET;
			s_q.mask <= `MASK_RESET;
			s_q.wr_state <= WR_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign s_axi_awready = s_q.wr_state == WR_COLLECT && !s_q.have_aw;
	assign s_axi_wready = s_q.wr_state == WR_COLLECT && !s_q.have_w;
	assign s_axi_bvalid = s_q.wr_state == WR_RESP;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_arready = !s_q.rvalid;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rdata = s_q.rdata;
	assign s_axi_rresp = s_q.rresp;

	// Wake follows any pending flag; enables gate what can become pending
	assign wake = |s_q.pending;
	assign irq = |(s_q.pending & s_q.mask);
endmodule // ext_irq_pin4_to_6_config
`default_nettype wire

// ---- gpio_source.sv ----
`default_nettype none
// ----------------------------------------
// External pin source
// ----------------------------------------
module gpio_source (
	input wire logic aclk,
	input wire logic [2:0] level_req,
	output logic [2:0] gpio
);
	timeunit 1ns;
	timeprecision 1ns;
	// Levels move just after an edge, like a synchronous board driver
	always @(posedge aclk) begin
		gpio <= level_req;
	end
endmodule // gpio_source
`default_nettype wire

// ---- ext_irq_properties.sv ----
`default_nettype none
module ext_irq_props #(
	parameter int NUM_PINS = 3
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic wake,
	input wire logic irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ----------------------------------------
	// Bus answers and flags
	// ----------------------------------------
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer missing");
	// Both items land in one edge; the write commits on the next, so bvalid shows a cycle later
	chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready |=> ##1 s_axi_bvalid) else $error("write answer missing");
	chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
		$stable(s_axi_bresp)) else $error("write answer dropped");
	chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
		$stable(s_axi_rdata)) else $error("read data dropped");
	chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	// Address 0x04 is outside the map, so it must answer with an error and zero
	chk_bad_addr: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h04 |=>
		s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("hole not refused");
	chk_irq_wake: assert property (irq |-> wake) else $error("irq without pending");
	// Pending flags only drop through a register write
	chk_wake_fall: assert property ($fell(wake) |-> s_axi_bvalid || !$past(aresetn))
		else $error("pending dropped without write");
	chk_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !wake && !irq &&
		!s_axi_bvalid && !s_axi_rvalid) else $error("outputs active after reset");
endmodule // ext_irq_props
bind ext_irq_pin4_to_6_config ext_irq_props #(.NUM_PINS(NUM_PINS)) u_props (.*);
`default_nettype wire

// ---- ext_irq_pin4_to_6_config_tb.sv ----
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
	$display("Error at %0t: got %h expected %h", $time, g, e); end end
module ext_irq_pin4_to_6_config_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import ext_irq_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	axil_req_t rq = '0;
	wire axil_rsp_t rs;
	logic [2:0] lvl = 3'h0;
	wire logic [2:0] gpio;
	wire logic wake;
	wire logic irq;
	int mismatches = 0;
	int samples_checked = 0;
	logic [31:0] expq[$];
	logic [31:0] exp_v;
	logic [31:0] d;
	ext_irq_pin4_to_6_config dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awvalid(rq.awvalid), .s_axi_awready(rs.awready), .s_axi_awaddr(rq.awaddr),
		.s_axi_wvalid(rq.wvalid), .s_axi_wready(rs.wready), .s_axi_wdata(rq.wdata),
		.s_axi_wstrb(rq.wstrb), .s_axi_bvalid(rs.bvalid), .s_axi_bready(rq.bready),
		.s_axi_bresp(rs.bresp), .s_axi_arvalid(rq.arvalid), .s_axi_arready(rs.arready),
		.s_axi_araddr(rq.araddr), .s_axi_rvalid(rs.rvalid), .s_axi_rready(rq.rready),
		.s_axi_rdata(rs.rdata), .s_axi_rresp(rs.rresp), .gpio_in(gpio), .wake(wake),
		.irq(irq));
	gpio_source src (.aclk(aclk), .level_req(lvl), .gpio(gpio));
	// ----------------------------------------
	// Clock, watchdog, closing
	// ----------------------------------------
	initial begin
		forever #25 aclk = ~aclk;
	end
	initial begin
		repeat (20000) @(posedge aclk);
		mismatches++;
		finish_test();
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Read data checked at mid-cycle, where nothing is moving
	always @(negedge aclk) begin
		if (rs.rvalid && rq.rready) begin
			exp_v = (expq.size() > 0) ? expq.pop_front() : 32'hdead0000;
			`CHK(rs.rdata, exp_v)
		end
	end
	// ----------------------------------------
	// Bus master; handshakes sampled at negedge, released after the edge
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic sa;
		logic sw;
		logic sb;
		logic [1:0] br;
		rq.awvalid <= 1'b1;
		rq.awaddr <= a;
		rq.wvalid <= 1'b1;
		rq.wdata <= v;
		rq.wstrb <= 4'hf;
		rq.bready <= 1'b1;
		do begin
			@(negedge aclk);
			sa = rq.awvalid && rs.awready;
			sw = rq.wvalid && rs.wready;
			sb = rs.bvalid;
			br = rs.bresp;
			@(posedge aclk);
			if (sa) rq.awvalid <= 1'b0;
			if (sw) rq.wvalid <= 1'b0;
		end while (!sb);
		rq.bready <= 1'b0;
		// Only the hole at 0x04 is written outside the map
		`CHK(br, (a == 8'h04) ? 2'h2 : 2'h0)
		// Let an edge pass so the next call never reassigns bready in this step
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic sa;
		logic sr;
		expq.push_back(e);
		rq.arvalid <= 1'b1;
		rq.araddr <= a;
		rq.rready <= 1'b1;
		do begin
			@(negedge aclk);
			sa = rq.arvalid && rs.arready;
			sr = rs.rvalid;
			@(posedge aclk);
			if (sa) rq.arvalid <= 1'b0;
		end while (!sr);
		rq.rready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic see(input logic [1:0] e);
		@(negedge aclk);
		`CHK({wake, irq}, e)
		@(posedge aclk);
	endtask
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		void'($urandom(32'h2b17b0c7));
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		see(2'b00);
		rd(8'h24, 32'h0);
		rd(8'h34, 32'h0);
		rd(8'h38, 32'h0);
		$display("test reset done");
		// Random patterns through every field, plus the self-clearing and hole addresses
		for (int i = 0; i < 4; i++) begin
			d = {16'h0, 16'($urandom())};
			wr(8'h24, d);
			rd(8'h24, d);
		end
		rd(8'h30, 32'h0);
		rd(8'h04, 32'h0);
		wr(8'h04, 32'h0);
		$display("test fields done");
		// Each pin alone enabled in each mode; all pins toggle so disabled ones must stay quiet
		for (int p = 0; p < 3; p++) begin
			for (int m = 0; m < 8; m++) begin
				wr(8'h24, 32'(4'h8 | 4'(m)) << (4 * p));
				repeat (6) @(posedge aclk);
				wr(8'h30, 32'h70);
				lvl <= 3'h7;
				repeat (6) @(posedge aclk);
				rd(8'h34, 32'(m != 1 && m != 5) << p);
				see({1'(m != 1 && m != 5), 1'b0});
				wr(8'h30, 32'h70);
				repeat (6) @(posedge aclk);
				rd(8'h34, 32'(m == 3 || m == 7) << p);
				wr(8'h30, 32'h70);
				lvl <= 3'h0;
				repeat (6) @(posedge aclk);
				rd(8'h34, 32'(m != 0) << p);
			end
		end
		$display("test modes done");
		// Interrupt raised, masked, then cleared through the status register
		wr(8'h24, 32'h8);
		wr(8'h38, 32'h7);
		wr(8'h30, 32'h70);
		lvl <= 3'h1;
		repeat (6) @(posedge aclk);
		see(2'b11);
		rd(8'h3c, 32'h1);
		wr(8'h38, 32'h0);
		see(2'b10);
		wr(8'h38, 32'h1);
		wr(8'h34, 32'h1);
		see(2'b00);
		rd(8'h38, 32'h1);
		$display("test interrupt done");
		finish_test();
	end
endmodule // ext_irq_pin4_to_6_config_tb
`default_nettype wire
